// File: verilog/cmp_event_pkg.sv
// Package: constants and types for the dual comparator event logic
`default_nettype none
package cmp_event_pkg;
   localparam logic [1:0] SRC_SYSCLK = 2'h0;
   localparam logic [1:0] SRC_T0 = 2'h1;
   localparam logic [1:0] SRC_T1 = 2'h2;
   localparam logic [1:0] SRC_T2 = 2'h3;
   localparam logic [2:0] MODE_LOW = 3'h0;
   localparam logic [2:0] MODE_HIGH = 3'h1;
   localparam logic [2:0] MODE_TOG_DB = 3'h2;
   localparam logic [2:0] MODE_RISE_DB = 3'h3;
   localparam logic [2:0] MODE_FALL_DB = 3'h4;
   localparam logic [2:0] MODE_TOG = 3'h5;
   localparam logic [2:0] MODE_RISE = 3'h6;
   localparam logic [2:0] MODE_FALL = 3'h7;
   localparam int CTRL_ENABLE_BIT = 3;
   localparam int CTRL_CONNECT_BIT = 5;
   localparam int CTRL_FLAG_BIT = 4;
   localparam int STABLE_SAMPLES = 4;
   localparam int DEBOUNCE_OVERFLOWS = 2;
   localparam logic [2:0] RESET_MODE = 3'h0;
   typedef enum logic [2:0] {
      DB_IDLE = 3'b001,
      DB_WAIT = 3'b010,
      DB_CHECK = 3'b100
   } db_state_e;
endpackage : cmp_event_pkg
`default_nettype wire

// File: verilog/cmp_channel.sv
// One comparator channel: input mux, sampling and event detection
`timescale 1ns/1ps
`default_nettype none
module cmp_channel
   import cmp_event_pkg::*;
#(
   parameter int STABLE_N = cmp_event_pkg::STABLE_SAMPLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic active,
   input wire logic [3:0] analog_input_pin,
   input wire logic [1:0] pos_channel_sel,
   input wire logic [2:0] ref_levels,
   input wire logic [1:0] reference_sel,
   input wire logic [2:0] irq_condition_sel,
   input wire logic [1:0] sample_source_sel,
   input wire logic [2:0] timer_overflow,
   input wire logic event_clear,
   output logic cmp_out,
   output logic event_flag
);
   initial begin
      if (STABLE_N < 1 || STABLE_N > 15) $error("STABLE_N out of range");
   end
   logic pos_in, neg_in, raw;
   logic smp_r, smp_nxt, acc_r, acc_nxt, flag_r, flag_nxt, out_r, out_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [1:0] ovf_r, ovf_nxt;
   logic tick, edge_ok, hit, is_db, t1;
   db_state_e st_r, st_nxt;
   always_comb begin
      pos_in = analog_input_pin[pos_channel_sel];
      neg_in = (reference_sel == 2'h0) ? ref_levels[1] : ref_levels[reference_sel - 2'h1];
      raw = active & (pos_in > neg_in);
      t1 = timer_overflow[1];
      case (sample_source_sel)
         SRC_T0: tick = timer_overflow[0];
         SRC_T1: tick = timer_overflow[1];
         SRC_T2: tick = timer_overflow[2];
         default: tick = 1'b1;
      endcase
      is_db = (irq_condition_sel >= MODE_TOG_DB) && (irq_condition_sel <= MODE_FALL_DB);
   end
   // Sampling and stability filter
   always_comb begin
      smp_nxt = smp_r;
      acc_nxt = acc_r;
      cnt_nxt = cnt_r;
      edge_ok = 1'b0;
      if (!active) begin
         smp_nxt = 1'b0;
         acc_nxt = 1'b0;
         cnt_nxt = 4'h0;
      end else if (tick) begin
         smp_nxt = raw;
         if (sample_source_sel == SRC_SYSCLK) begin
            edge_ok = raw != acc_r;
            acc_nxt = raw;
         end else if (raw == acc_r) begin
            cnt_nxt = 4'h0;
         end else if (cnt_r == 4'(STABLE_N - 1)) begin
            edge_ok = 1'b1;
            acc_nxt = raw;
            cnt_nxt = 4'h0;
         end else begin
            cnt_nxt = cnt_r + 4'h1;
         end
      end
   end
   // Debounce sequencer and flag
   always_comb begin
      st_nxt = st_r;
      ovf_nxt = ovf_r;
      out_nxt = out_r;
      hit = 1'b0;
      case (st_r)
         DB_IDLE: begin
            if (active && is_db && edge_ok && sample_source_sel == SRC_SYSCLK) begin
               if ((irq_condition_sel == MODE_TOG_DB) || (irq_condition_sel == MODE_RISE_DB && raw) ||
                   (irq_condition_sel == MODE_FALL_DB && !raw)) begin
                  st_nxt = DB_WAIT;
                  out_nxt = raw;
                  ovf_nxt = 2'h0;
               end
            end else if (active && is_db && edge_ok) begin
               hit = (irq_condition_sel == MODE_TOG_DB) || (irq_condition_sel == MODE_RISE_DB && raw) ||
                     (irq_condition_sel == MODE_FALL_DB && !raw);
            end
         end
         DB_WAIT: begin
            if (t1) ovf_nxt = ovf_r + 2'h1;
            if (t1 && ovf_r == 2'(DEBOUNCE_OVERFLOWS - 1)) st_nxt = DB_CHECK;
         end
         DB_CHECK: begin
            hit = raw == out_r;
            st_nxt = DB_IDLE;
         end
         default: st_nxt = DB_IDLE;
      endcase
      if (!active || !is_db) st_nxt = DB_IDLE;
      if (active && !is_db && tick) begin
         case (irq_condition_sel)
            MODE_LOW: hit = !raw;
            MODE_HIGH: hit = raw;
            MODE_TOG: hit = edge_ok;
            MODE_RISE: hit = edge_ok && raw;
            default: hit = edge_ok && !raw;
         endcase
      end
      flag_nxt = hit | (flag_r & ~event_clear);
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         smp_r <= 1'b0;
         acc_r <= 1'b0;
         cnt_r <= 4'h0;
         st_r <= DB_IDLE;
         ovf_r <= 2'h0;
         out_r <= 1'b0;
         flag_r <= 1'b0;
      end else begin
         smp_r <= smp_nxt;
         acc_r <= acc_nxt;
         cnt_r <= cnt_nxt;
         st_r <= st_nxt;
         ovf_r <= ovf_nxt;
         out_r <= out_nxt;
         flag_r <= flag_nxt;
      end
   end
   assign cmp_out = smp_r;
   assign event_flag = flag_r;
   level_flag_a: assert property (@(posedge core_clk) disable iff (rst)
      active && tick && irq_condition_sel == MODE_HIGH && raw |=> event_flag) else $error("level flag missed");
   flag_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      event_flag && !event_clear |=> event_flag) else $error("flag lost");
   off_out_a: assert property (@(posedge core_clk) disable iff (rst)
      !active |=> !cmp_out) else $error("output while off");
   db_gap_a: assert property (@(posedge core_clk) disable iff (rst)
      st_r == DB_IDLE && st_nxt == DB_WAIT |=> st_r == DB_WAIT [*2]) else $error("debounce too short");
   stab_a: assert property (@(posedge core_clk) disable iff (rst)
      edge_ok && sample_source_sel != SRC_SYSCLK |-> cnt_r == 4'(STABLE_N - 1)) else $error("edge before stable");
   mux_a: assert property (@(posedge core_clk) disable iff (rst)
      active && tick |=> cmp_out == $past(raw)) else $error("sample wrong");
   sel_a: assert property (@(posedge core_clk) disable iff (rst)
      pos_in == analog_input_pin[pos_channel_sel]) else $error("mux wrong");
   ref_a: assert property (@(posedge core_clk) disable iff (rst)
      reference_sel == 2'h0 |-> neg_in == ref_levels[1]) else $error("ref wrong");
   db_c: cover property (@(posedge core_clk) st_r == DB_CHECK && hit);
   edge_c: cover property (@(posedge core_clk) edge_ok && sample_source_sel != SRC_SYSCLK);
   lvl_c: cover property (@(posedge core_clk) hit && irq_condition_sel == MODE_LOW);
endmodule : cmp_channel
`default_nettype wire

// File: verilog/dual_comparator_event_logic.sv
// Top level: two comparator channels and the shared interrupt request
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_event_logic
   import cmp_event_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] analog_input_pin,
   input wire logic [2:0] internal_ref_level,
   input wire logic cmp_a_enable,
   input wire logic cmp_b_enable,
   input wire logic cmp_a_input_connect,
   input wire logic cmp_b_input_connect,
   input wire logic [1:0] cmp_a_pos_channel_sel,
   input wire logic [1:0] cmp_b_pos_channel_sel,
   input wire logic [1:0] cmp_a_reference_sel,
   input wire logic [1:0] cmp_b_reference_sel,
   input wire logic [1:0] cmp_a_sample_source_sel,
   input wire logic [1:0] cmp_b_sample_source_sel,
   input wire logic [2:0] cmp_a_irq_condition_sel,
   input wire logic [2:0] cmp_b_irq_condition_sel,
   input wire logic [2:0] timer_overflow,
   input wire logic [1:0] cmp_flag_clear,
   input wire logic cmp_irq_enable,
   input wire logic power_down,
   output logic [1:0] cmp_out,
   output logic [1:0] cmp_event_flag,
   output logic cmp_irq
);
   logic act_a, act_b;
   always_comb begin
      act_a = cmp_a_enable & cmp_a_input_connect & ~power_down;
      act_b = cmp_b_enable & cmp_b_input_connect & ~power_down;
      cmp_irq = cmp_irq_enable & (|cmp_event_flag);
   end
   cmp_channel u_cmp_a (
      .core_clk(core_clk),
      .rst(rst),
      .active(act_a),
      .analog_input_pin(analog_input_pin),
      .pos_channel_sel(cmp_a_pos_channel_sel),
      .ref_levels(internal_ref_level),
      .reference_sel(cmp_a_reference_sel),
      .irq_condition_sel(cmp_a_irq_condition_sel),
      .sample_source_sel(cmp_a_sample_source_sel),
      .timer_overflow(timer_overflow),
      .event_clear(cmp_flag_clear[0]),
      .cmp_out(cmp_out[0]),
      .event_flag(cmp_event_flag[0])
   );
   cmp_channel u_cmp_b (
      .core_clk(core_clk),
      .rst(rst),
      .active(act_b),
      .analog_input_pin(analog_input_pin),
      .pos_channel_sel(cmp_b_pos_channel_sel),
      .ref_levels(internal_ref_level),
      .reference_sel(cmp_b_reference_sel),
      .irq_condition_sel(cmp_b_irq_condition_sel),
      .sample_source_sel(cmp_b_sample_source_sel),
      .timer_overflow(timer_overflow),
      .event_clear(cmp_flag_clear[1]),
      .cmp_out(cmp_out[1]),
      .event_flag(cmp_event_flag[1])
   );
   irq_join_a: assert property (@(posedge core_clk) disable iff (rst)
      cmp_irq_enable && cmp_event_flag[1] |-> cmp_irq) else $error("shared irq missing");
   pd_off_a: assert property (@(posedge core_clk) disable iff (rst)
      power_down [*2] |-> cmp_out == 2'h0) else $error("running in power-down");
   irq_c: cover property (@(posedge core_clk) cmp_irq && cmp_event_flag == 2'h3);
endmodule : dual_comparator_event_logic
`default_nettype wire

// File: testbench/dual_comparator_event_logic_bench.sv
// Self-checking bench for the dual comparator event logic
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_event_logic_bench;
   import cmp_event_pkg::*;
   logic core_clk, rst, cmp_a_enable, cmp_b_enable, cmp_a_input_connect, cmp_b_input_connect;
   logic cmp_irq_enable, power_down, cmp_irq;
   logic [3:0] analog_input_pin;
   logic [2:0] internal_ref_level, cmp_a_irq_condition_sel, cmp_b_irq_condition_sel, timer_overflow;
   logic [1:0] cmp_a_pos_channel_sel, cmp_b_pos_channel_sel, cmp_a_reference_sel, cmp_b_reference_sel;
   logic [1:0] cmp_a_sample_source_sel, cmp_b_sample_source_sel, cmp_flag_clear, cmp_out, cmp_event_flag;
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;
   dual_comparator_event_logic dut (.core_clk(core_clk), .rst(rst), .analog_input_pin(analog_input_pin),
      .internal_ref_level(internal_ref_level), .cmp_a_enable(cmp_a_enable), .cmp_b_enable(cmp_b_enable),
      .cmp_a_input_connect(cmp_a_input_connect), .cmp_b_input_connect(cmp_b_input_connect),
      .cmp_a_pos_channel_sel(cmp_a_pos_channel_sel), .cmp_b_pos_channel_sel(cmp_b_pos_channel_sel),
      .cmp_a_reference_sel(cmp_a_reference_sel), .cmp_b_reference_sel(cmp_b_reference_sel),
      .cmp_a_sample_source_sel(cmp_a_sample_source_sel), .cmp_b_sample_source_sel(cmp_b_sample_source_sel),
      .cmp_a_irq_condition_sel(cmp_a_irq_condition_sel), .cmp_b_irq_condition_sel(cmp_b_irq_condition_sel),
      .timer_overflow(timer_overflow), .cmp_flag_clear(cmp_flag_clear), .cmp_irq_enable(cmp_irq_enable),
      .power_down(power_down), .cmp_out(cmp_out), .cmp_event_flag(cmp_event_flag), .cmp_irq(cmp_irq));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(negedge core_clk);
   endtask : step
   task automatic pulse(input int idx);
      timer_overflow = 3'h1 << idx;
      step(1);
      timer_overflow = 3'h0;
      step(1);
   endtask : pulse
   task automatic clr();
      cmp_flag_clear = 2'h3;
      step(1);
      cmp_flag_clear = 2'h0;
      step(1);
   endtask : clr
   task automatic cfg(input logic [2:0] m, input logic [1:0] s);
      {cmp_a_enable, cmp_b_enable, cmp_a_input_connect, cmp_b_input_connect, cmp_irq_enable} = 5'h00;
      analog_input_pin = 4'h0;
      {cmp_a_irq_condition_sel, cmp_b_irq_condition_sel} = {m, m};
      {cmp_a_sample_source_sel, cmp_b_sample_source_sel} = {s, s};
      step(2);
      {cmp_a_enable, cmp_b_enable, cmp_a_input_connect, cmp_b_input_connect} = 4'hF;
      step(500);
      clr();
      cmp_irq_enable = 1'b1;
   endtask : cfg
   task automatic t_modes();
      logic [7:0] r_tab, f_tab;
      r_tab = 8'h63;
      f_tab = 8'hA3;
      for (int m = 0; m < 8; m++) begin
         cfg(3'(m), SRC_SYSCLK);
         analog_input_pin = 4'hF;
         step(3);
         chk("flag after rise", {2{r_tab[m]}}, cmp_event_flag);
         chk("irq after rise", {1'b0, r_tab[m]}, {1'b0, cmp_irq});
         clr();
         analog_input_pin = 4'h0;
         step(3);
         chk("flag after fall", {2{f_tab[m]}}, cmp_event_flag);
      end
      $display("test modes done");
   endtask : t_modes
   task automatic t_sel_ref();
      cfg(MODE_HIGH, SRC_SYSCLK);
      for (int i = 0; i < 4; i++) begin
         {cmp_a_pos_channel_sel, cmp_b_pos_channel_sel} = {2'(i), 2'(i + 1)};
         analog_input_pin = 4'h1 << i;
         step(3);
         chk("channel routing", 2'h1, cmp_out);
      end
      {cmp_a_pos_channel_sel, analog_input_pin, internal_ref_level} = {2'h0, 4'hF, 3'h2};
      for (int i = 0; i < 4; i++) begin
         cmp_a_reference_sel = 2'(i);
         step(3);
         chk("reference tap", {1'b0, 1'(i % 2)}, {1'b0, cmp_out[0]});
      end
      {internal_ref_level, cmp_a_reference_sel} = 5'h00;
      $display("test selection done");
   endtask : t_sel_ref
   task automatic t_enable();
      cfg(MODE_HIGH, SRC_SYSCLK);
      analog_input_pin = 4'hF;
      cmp_b_enable = 1'b0;
      step(3);
      clr();
      chk("b disabled", 2'h1, cmp_event_flag);
      cmp_irq_enable = 1'b0;
      step(1);
      chk("irq masked", 2'h0, {1'b0, cmp_irq});
      cmp_irq_enable = 1'b1;
      {cmp_b_enable, cmp_a_input_connect} = 2'h2;
      step(3);
      clr();
      chk("a disconnected", 2'h2, cmp_event_flag);
      chk("irq from b", 2'h1, {1'b0, cmp_irq});
      {cmp_a_input_connect, power_down} = 2'h3;
      step(3);
      clr();
      chk("power down out", 2'h0, cmp_out);
      chk("power down flag", 2'h0, cmp_event_flag);
      power_down = 1'b0;
      $display("test enables done");
   endtask : t_enable
   task automatic t_src();
      for (int s = 1; s < 4; s++) begin
         cfg(MODE_RISE, 2'(s));
         analog_input_pin = 4'hF;
         step(3);
         chk("no tick no sample", 2'h0, cmp_out);
         repeat (3) pulse(s - 1);
         step(2);
         chk("edge before stable", 2'h0, cmp_event_flag);
         repeat (1) pulse(s - 1);
         step(2);
         chk("edge after stable", 2'h3, cmp_event_flag);
      end
      $display("test sources done");
   endtask : t_src
   task automatic t_debounce();
      cfg(MODE_RISE_DB, SRC_SYSCLK);
      analog_input_pin = 4'hF;
      step(3);
      pulse(1);
      step(2);
      chk("debounce waiting", 2'h0, cmp_event_flag);
      pulse(1);
      step(3);
      chk("debounce accepted", 2'h3, cmp_event_flag);
      cfg(MODE_FALL_DB, SRC_SYSCLK);
      analog_input_pin = 4'hF;
      step(3);
      analog_input_pin = 4'h0;
      step(2);
      pulse(1);
      analog_input_pin = 4'hF;
      pulse(1);
      step(3);
      chk("glitch ignored", 2'h0, cmp_event_flag);
      $display("test debounce done");
   endtask : t_debounce
   initial begin
      {rst, cmp_a_enable, cmp_b_enable, cmp_a_input_connect, cmp_b_input_connect} = 5'h1F;
      {analog_input_pin, internal_ref_level, timer_overflow, cmp_flag_clear} = 12'h000;
      {cmp_a_pos_channel_sel, cmp_b_pos_channel_sel, cmp_a_reference_sel, cmp_b_reference_sel} = 8'h00;
      {cmp_a_sample_source_sel, cmp_b_sample_source_sel, cmp_a_irq_condition_sel} = 7'h00;
      {cmp_b_irq_condition_sel, cmp_irq_enable, power_down} = 5'h2;
      step(5);
      rst = 1'b0;
      chk("reset flags", 2'h0, cmp_event_flag);
      t_modes();
      t_sel_ref();
      t_enable();
      t_src();
      t_debounce();
      end_sim();
   end
endmodule : dual_comparator_event_logic_bench
`default_nettype wire
